// *** design/alm_pkg.sv ***
`default_nettype none
package alm_pkg;

    // ========================================================
    // Sizes and timing
    localparam int ALM_NCH       = 4;
    localparam int ALM_NLIM      = 4;
    localparam int ALM_NDIN      = 4;
    localparam int ALM_CLK_HZ    = 50_000_000;
    localparam int ALM_GAP_MS    = 25;
    // Longest gap between passes, rounded down to whole cycles
    localparam int ALM_GAP_CYC   = (ALM_CLK_HZ / 1000) * ALM_GAP_MS;

    // ========================================================
    // Register map (byte addresses)
    localparam logic [7:0] ALM_CH_BASE    = 8'h00;
    localparam logic [7:0] ALM_CH_STRIDE  = 8'h20;
    localparam logic [2:0] ALM_CH_CFG     = 3'h0;
    localparam logic [2:0] ALM_CH_G1      = 3'h1;
    localparam logic [2:0] ALM_CH_G2      = 3'h2;
    localparam logic [2:0] ALM_CH_DLY     = 3'h3;
    localparam logic [7:0] ALM_LIM_BASE   = 8'h80;
    localparam logic [7:0] ALM_LIM_STRIDE = 8'h10;
    localparam logic [1:0] ALM_LIM_ON     = 2'h0;
    localparam logic [1:0] ALM_LIM_OFF    = 2'h1;
    localparam logic [1:0] ALM_LIM_HOURS  = 2'h2;
    localparam logic [7:0] ALM_STATUS     = 8'hC0;
    localparam logic [7:0] ALM_CMD        = 8'hC4;

    // ========================================================
    // Reset values and write masks
    localparam logic [31:0] ALM_CH_CFG_RST  = 32'h0000_0009;
    localparam logic [31:0] ALM_CH_CFG_MASK = 32'h0007_FFFF;
    localparam logic [31:0] ALM_G1_MASK     = 32'h0003_FFFF;
    localparam logic [31:0] ALM_G2_MASK     = 32'h0007_FFFF;
    localparam logic [31:0] ALM_ZERO        = 32'h0000_0000;

    // ========================================================
    // Source pool indices for gate inputs
    localparam logic [4:0] ALM_SRC_LIM = 5'h00;
    localparam logic [4:0] ALM_SRC_Y   = 5'h04;
    localparam logic [4:0] ALM_SRC_Z   = 5'h08;
    localparam logic [4:0] ALM_SRC_D   = 5'h0C;
    localparam logic [4:0] ALM_SRC_A   = 5'h10;
    localparam logic [4:0] ALM_SRC_DIN = 5'h14;

    // Reset source enable bits
    localparam int ALM_RS_DISP  = 0;
    localparam int ALM_RS_DIN   = 1;
    localparam int ALM_RS_LOGIC = 2;
    localparam int ALM_RS_BUS   = 3;

    // ========================================================
    // Types
    typedef enum logic [2:0] {
        ALM_AND  = 3'b000,
        ALM_OR   = 3'b001,
        ALM_XOR  = 3'b010,
        ALM_NAND = 3'b011,
        ALM_NOR  = 3'b100,
        ALM_XNOR = 3'b101
    } alm_gate_e;

    typedef enum logic [2:0] {
        ALM_ST_IDLE = 3'b000,
        ALM_ST_LIM  = 3'b001,
        ALM_ST_Y    = 3'b010,
        ALM_ST_Z    = 3'b011,
        ALM_ST_D    = 3'b100,
        ALM_ST_A    = 3'b101
    } alm_state_e;

    typedef struct packed {
        logic [12:0] rsvd;
        logic [4:0]  rst_logic_sel;
        logic [1:0]  rst_din_sel;
        logic [3:0]  rst_src_en;
        logic        invert;
        logic        latch;
        alm_gate_e   g2;
        alm_gate_e   g1;
    } alm_chcfg_s;

    typedef struct packed {
        logic [13:0]     rsvd;
        logic [2:0]      used;
        logic [2:0][4:0] sel;
    } alm_g1_s;

    typedef struct packed {
        logic [12:0]     rsvd;
        logic [3:0]      used;
        logic [2:0][4:0] sel;
    } alm_g2_s;

    typedef struct packed {
        logic [15:0] dropout;
        logic [15:0] switch_in;
    } alm_dly_s;

endpackage
`default_nettype wire

// *** design/alm_logic.sv ***
// Chosen here: the address map and the AHB-Lite interface to the registers.
`timescale 1ns/10ps
`default_nettype none

module alm_logic
    import alm_pkg::*;
#(
    parameter int GAP_CYC = ALM_GAP_CYC
) (
    // Clock and reset
    input  wire logic                         hclk,
    input  wire logic                         hresetn,
    // AHB-Lite slave
    input  wire logic                         hsel,
    input  wire logic [31:0]                  haddr,
    input  wire logic [1:0]                   htrans,
    input  wire logic                         hwrite,
    input  wire logic [2:0]                   hsize,
    input  wire logic [31:0]                  hwdata,
    input  wire logic                         hready,
    output logic      [31:0]                  hrdata,
    output logic                              hreadyout,
    output logic                              hresp,
    // Measured values, same clock
    input  wire logic [ALM_NLIM-1:0][31:0]    meas_value,
    // Pins
    input  wire logic                         line_cycle,
    input  wire logic [ALM_NDIN-1:0]          digital_in,
    input  wire logic                         display_reset,
    // Logic states
    output logic      [ALM_NLIM-1:0]          limit_state,
    output logic      [ALM_NCH-1:0]           first_level_result,
    output logic      [ALM_NCH-1:0]           combined_logic_output,
    output logic      [ALM_NCH-1:0]           delayed_logic_state,
    output logic      [ALM_NCH-1:0]           function_output,
    output logic      [ALM_NCH-1:0]           follow_up
);

    // ========================================================
    // Gate evaluation with neutral unused inputs
    function automatic logic gate_eval(input alm_gate_e g, input logic [3:0] v,
                                       input logic [3:0] used);
        logic [3:0] a;
        logic       all1;
        logic       any1;
        a    = v & used;
        all1 = (a == used);
        any1 = |a;
        case (g)
            ALM_AND:  gate_eval = all1;
            ALM_NAND: gate_eval = ~all1;
            ALM_OR:   gate_eval = any1;
            ALM_NOR:  gate_eval = ~any1;
            ALM_XOR:  gate_eval = $onehot(a);
            ALM_XNOR: gate_eval = all1 | ~any1;
            default:  gate_eval = 1'b0;
        endcase
    endfunction

    // ========================================================
    // Register storage
    alm_chcfg_s          cfg_q   [ALM_NCH];
    alm_g1_s             g1_q    [ALM_NCH];
    alm_g2_s             g2_q    [ALM_NCH];
    alm_dly_s            dly_q   [ALM_NCH];
    logic signed [31:0]  on_q    [ALM_NLIM];
    logic signed [31:0]  off_q   [ALM_NLIM];
    logic [31:0]         hours_q [ALM_NLIM];

    // Logic state
    alm_state_e          st_q;
    alm_state_e          st_d;
    logic [1:0]          idx_q;
    logic [ALM_NLIM-1:0] lim_q;
    logic [ALM_NCH-1:0]  y_q;
    logic [ALM_NCH-1:0]  y_prev_q;
    logic [ALM_NCH-1:0]  z_q;
    logic [ALM_NCH-1:0]  d_q;
    logic [ALM_NCH-1:0]  a_q;
    logic [ALM_NCH-1:0]  s_q;
    logic [15:0]         dcnt_q  [ALM_NCH];
    logic [ALM_NCH-1:0]  rst_pend_q;

    // ========================================================
    // Pin synchronisers and edge detection
    logic [ALM_NDIN+1:0] pin_s1_q;
    logic [ALM_NDIN+1:0] pin_s2_q;
    logic [ALM_NDIN+1:0] pin_s3_q;
    wire  [ALM_NDIN+1:0] pin_rise = pin_s2_q & ~pin_s3_q;
    wire  [ALM_NDIN-1:0] din_s    = pin_s2_q[ALM_NDIN-1:0];
    wire                 cyc_rise = pin_rise[ALM_NDIN];
    wire                 disp_rise = pin_rise[ALM_NDIN+1];

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            pin_s1_q <= '0;
            pin_s2_q <= '0;
            pin_s3_q <= '0;
        end else begin
            pin_s1_q <= {display_reset, line_cycle, digital_in};
            pin_s2_q <= pin_s1_q;
            pin_s3_q <= pin_s2_q;
        end
    end

    // ========================================================
    // AHB-Lite slave, zero wait states, always OKAY
    logic        wr_q;
    logic [7:0]  addr_q;
    logic [31:0] rdata_q;
    wire         take     = hsel & hready & htrans[1];
    wire  [7:0]  ra       = haddr[7:0];
    wire  [1:0]  r_ch     = ra[6:5];
    wire  [1:0]  r_lim    = ra[5:4];
    wire         r_is_ch  = ~ra[7] & ~ra[4];
    wire         r_is_lim = (ra[7:6] == ALM_LIM_BASE[7:6]);
    wire  [1:0]  w_ch     = addr_q[6:5];
    wire  [1:0]  w_lim    = addr_q[5:4];
    wire         w_is_ch  = wr_q & ~addr_q[7] & ~addr_q[4];
    wire         w_is_lim = wr_q & (addr_q[7:6] == ALM_LIM_BASE[7:6]);
    wire         w_cmd    = wr_q & (addr_q == ALM_CMD);
    wire  [31:0] status_w = {8'h00, s_q, a_q, d_q, z_q, y_q, lim_q};

    function automatic logic [31:0] ch_read(input logic [1:0] c, input logic [2:0] r);
        case (r)
            ALM_CH_CFG: ch_read = 32'(cfg_q[c]);
            ALM_CH_G1:  ch_read = 32'(g1_q[c]);
            ALM_CH_G2:  ch_read = 32'(g2_q[c]);
            ALM_CH_DLY: ch_read = 32'(dly_q[c]);
            default:    ch_read = ALM_ZERO;
        endcase
    endfunction

    function automatic logic [31:0] lim_read(input logic [1:0] l, input logic [1:0] r);
        case (r)
            ALM_LIM_ON:    lim_read = on_q[l];
            ALM_LIM_OFF:   lim_read = off_q[l];
            ALM_LIM_HOURS: lim_read = hours_q[l];
            default:       lim_read = ALM_ZERO;
        endcase
    endfunction

    wire [31:0] rd_word = r_is_ch  ? ch_read(r_ch, ra[4:2]) :
                          r_is_lim ? lim_read(r_lim, ra[3:2]) :
                          (ra == ALM_STATUS) ? status_w : ALM_ZERO;

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            wr_q    <= 1'b0;
            addr_q  <= '0;
            rdata_q <= '0;
        end else begin
            wr_q    <= take & hwrite;
            addr_q  <= ra;
            rdata_q <= (take & ~hwrite) ? rd_word : ALM_ZERO;
        end
    end

    assign hrdata    = rdata_q;
    assign hreadyout = 1'b1;
    assign hresp     = 1'b0;

    // ========================================================
    // Pass sequencer
    logic [31:0] gap_q;
    logic        start_pend_q;
    wire         gap_hit = (gap_q >= 32'(GAP_CYC - 1));
    wire         start   = start_pend_q | cyc_rise | gap_hit;

    always_comb begin
        st_d = st_q;
        case (st_q)
            ALM_ST_IDLE: st_d = start ? ALM_ST_LIM : ALM_ST_IDLE;
            ALM_ST_LIM:  st_d = ALM_ST_Y;
            ALM_ST_Y:    st_d = (idx_q == 2'(ALM_NCH - 1)) ? ALM_ST_Z : ALM_ST_Y;
            ALM_ST_Z:    st_d = ALM_ST_D;
            ALM_ST_D:    st_d = ALM_ST_A;
            ALM_ST_A:    st_d = ALM_ST_IDLE;
            default:     st_d = ALM_ST_IDLE;
        endcase
    end

    // Gap counter restarts at every pass start, so passes stay within the limit
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            st_q         <= ALM_ST_IDLE;
            idx_q        <= '0;
            gap_q        <= '0;
            start_pend_q <= 1'b0;
        end else begin
            st_q         <= st_d;
            idx_q        <= (st_q == ALM_ST_Y) ? idx_q + 2'd1 : 2'd0;
            gap_q        <= (st_q == ALM_ST_LIM) ? 32'd1 : gap_q + 32'd1;
            start_pend_q <= (st_q != ALM_ST_IDLE) & (start_pend_q | cyc_rise);
        end
    end

    // ========================================================
    // Source pools: first level sees live results, the rest see last pass
    wire [31:0] pool1 = {8'h00, din_s, a_q, d_q, z_q, y_q, lim_q};
    wire [31:0] pool2 = {8'h00, din_s, a_q, d_q, z_q, y_prev_q, lim_q};

    // First-level result of the channel being evaluated
    alm_g1_s    g1_cur;
    assign g1_cur = g1_q[idx_q];
    wire        y_new = gate_eval(cfg_q[idx_q].g1,
                                  {1'b0, pool1[g1_cur.sel[2]], pool1[g1_cur.sel[1]],
                                   pool1[g1_cur.sel[0]]}, {1'b0, g1_cur.used});

    // ========================================================
    // Limit comparators and operating-hour counters
    genvar l;
    generate
        for (l = 0; l < ALM_NLIM; l++) begin : g_lim
            wire signed [31:0] v     = meas_value[l];
            wire               upper = (on_q[l] >= off_q[l]);
            wire               lim_d = upper ?
                (v > on_q[l] ? 1'b1 : (v < off_q[l] ? 1'b0 : lim_q[l])) :
                (v < on_q[l] ? 1'b1 : (v > off_q[l] ? 1'b0 : lim_q[l]));
            wire               wsel  = w_is_lim & (w_lim == 2'(l));
            always_ff @(posedge hclk or negedge hresetn) begin
                if (!hresetn) begin
                    lim_q[l]   <= 1'b0;
                    on_q[l]    <= '0;
                    off_q[l]   <= '0;
                    hours_q[l] <= '0;
                end else begin
                    if (st_q == ALM_ST_LIM) begin
                        lim_q[l]   <= lim_d;
                        hours_q[l] <= hours_q[l] + 32'(lim_q[l]);
                    end
                    if (wsel && addr_q[3:2] == ALM_LIM_ON) begin
                        on_q[l] <= hwdata;
                    end
                    if (wsel && addr_q[3:2] == ALM_LIM_OFF) begin
                        off_q[l] <= hwdata;
                    end
                end
            end
        end
    endgenerate

    // ========================================================
    // Channels
    genvar c;
    generate
        for (c = 0; c < ALM_NCH; c++) begin : g_ch
            alm_chcfg_s cfg;
            alm_g2_s    g2;
            assign cfg = cfg_q[c];
            assign g2  = g2_q[c];
            wire        wsel  = w_is_ch & (w_ch == 2'(c));
            wire        z_new = gate_eval(cfg.g2,
                                          {pool2[g2.sel[2]], pool2[g2.sel[1]],
                                           pool2[g2.sel[0]], y_q[c]}, g2.used);
            wire [15:0] dly   = z_q[c] ? dly_q[c].switch_in : dly_q[c].dropout;
            wire        d_dn  = (z_q[c] != d_q[c]) & (dcnt_q[c] >= dly);
            // Reset events caught between passes, consumed at function stage
            wire        ev    = (cfg.rst_src_en[ALM_RS_DISP] & disp_rise) |
                                (cfg.rst_src_en[ALM_RS_DIN] & pin_rise[cfg.rst_din_sel]) |
                                (cfg.rst_src_en[ALM_RS_BUS] & w_cmd & hwdata[c]);
            wire        lrst  = cfg.rst_src_en[ALM_RS_LOGIC] & pool2[cfg.rst_logic_sel];
            wire        rst_n = rst_pend_q[c] | lrst;
            // Latched action is released only by a reset while the delayed state is low
            wire        a_new = cfg.latch ? (d_q[c] | (a_q[c] & ~rst_n)) :
                                            d_q[c];
            wire        stA   = (st_q == ALM_ST_A);

            always_ff @(posedge hclk or negedge hresetn) begin
                if (!hresetn) begin
                    y_q[c]        <= 1'b0;
                    y_prev_q[c]   <= 1'b0;
                    z_q[c]        <= 1'b0;
                    d_q[c]        <= 1'b0;
                    a_q[c]        <= 1'b0;
                    s_q[c]        <= 1'b0;
                    dcnt_q[c]     <= '0;
                    rst_pend_q[c] <= 1'b0;
                end else begin
                    if (st_q == ALM_ST_LIM) begin
                        y_prev_q[c] <= y_q[c];
                    end
                    if (st_q == ALM_ST_Y && idx_q == 2'(c)) begin
                        y_q[c] <= y_new;
                    end
                    if (st_q == ALM_ST_Z) begin
                        z_q[c] <= z_new;
                    end
                    if (st_q == ALM_ST_D) begin
                        d_q[c]    <= d_dn ? z_q[c] : d_q[c];
                        dcnt_q[c] <= (z_q[c] == d_q[c] || d_dn) ? 16'd0 : dcnt_q[c] + 16'd1;
                    end
                    if (stA) begin
                        a_q[c] <= a_new;
                        s_q[c] <= a_new ^ cfg.invert;
                    end
                    // A fresh event wins over the consume in the same cycle
                    rst_pend_q[c] <= (rst_pend_q[c] & ~stA) | ev;
                end
            end

            always_ff @(posedge hclk or negedge hresetn) begin
                if (!hresetn) begin
                    cfg_q[c] <= alm_chcfg_s'(ALM_CH_CFG_RST);
                    g1_q[c]  <= '0;
                    g2_q[c]  <= '0;
                    dly_q[c] <= '0;
                end else if (wsel) begin
                    case (addr_q[4:2])
                        ALM_CH_CFG: cfg_q[c] <= alm_chcfg_s'(hwdata & ALM_CH_CFG_MASK);
                        ALM_CH_G1:  g1_q[c]  <= alm_g1_s'(hwdata & ALM_G1_MASK);
                        ALM_CH_G2:  g2_q[c]  <= alm_g2_s'(hwdata & ALM_G2_MASK);
                        ALM_CH_DLY: dly_q[c] <= alm_dly_s'(hwdata);
                        default:    dly_q[c] <= dly_q[c];
                    endcase
                end
            end
        end
    endgenerate

    // ========================================================
    // Outputs
    assign limit_state           = lim_q;
    assign first_level_result    = y_q;
    assign combined_logic_output = z_q;
    assign delayed_logic_state   = d_q;
    assign function_output       = a_q;
    assign follow_up             = s_q;

endmodule

`default_nettype wire

// *** tb/alm_logic_checker.sv ***
`timescale 1ns/10ps
`default_nettype none
module alm_logic_checker
    import alm_pkg::*;
(
    // Clock and reset
    input wire logic                hclk,
    input wire logic                hresetn,
    // Channel states
    input wire logic [ALM_NLIM-1:0] limit_state,
    input wire logic [ALM_NCH-1:0]  first_level_result,
    input wire logic [ALM_NCH-1:0]  combined_logic_output,
    input wire logic [ALM_NCH-1:0]  delayed_logic_state,
    input wire logic [ALM_NCH-1:0]  function_output,
    input wire logic [ALM_NCH-1:0]  follow_up
);
    default clocking cb @(posedge hclk); endclocking
    default disable iff (!hresetn);

    // ========
    // Pass stages, each alone in its own cycle
    sequence lim_step; $changed(limit_state); endsequence
    sequence z_step; $changed(combined_logic_output); endsequence
    sequence d_step; $changed(delayed_logic_state); endsequence
    sequence a_step; $changed(function_output) || $changed(follow_up); endsequence

    lim_alone_a: assert property (lim_step |-> $stable(first_level_result)
        && $stable(combined_logic_output) && $stable(function_output)) else $error("limit overlap");
    y_single_a: assert property ($changed(first_level_result) |->
        $onehot(first_level_result ^ $past(first_level_result))) else $error("first level burst");
    z_alone_a: assert property (z_step |-> $stable(limit_state)
        && $stable(first_level_result) && $stable(delayed_logic_state)) else $error("combine overlap");
    d_takes_z_a: assert property (d_step |-> ((delayed_logic_state
        ^ $past(delayed_logic_state)) & (delayed_logic_state ^ combined_logic_output)) == '0)
        else $error("delayed state not from combined output");
    // A second pass can follow at once, but never closer than nine cycles
    d_spacing_a: assert property (d_step |=> $stable(delayed_logic_state)[*8])
        else $error("passes too close");
    a_rise_a: assert property ($changed(function_output) |-> (function_output
        & ~$past(function_output) & ~delayed_logic_state) == '0) else $error("function rose alone");
    a_fall_a: assert property ($changed(function_output) |-> (~function_output
        & $past(function_output) & delayed_logic_state) == '0) else $error("function fell early");
    a_stage_a: assert property (a_step |-> $stable(delayed_logic_state)
        && $stable(combined_logic_output) && $stable(limit_state)) else $error("action overlap");
endmodule

bind alm_logic alm_logic_checker u_chk (.hclk(hclk), .hresetn(hresetn),
    .limit_state(limit_state), .first_level_result(first_level_result),
    .combined_logic_output(combined_logic_output), .delayed_logic_state(delayed_logic_state),
    .function_output(function_output), .follow_up(follow_up));
`default_nettype wire

// *** tb/alm_field.sv ***
`timescale 1ns/10ps
`default_nettype none
module alm_field (
    // Clock
    input  wire logic       hclk,
    // Pins into the alarm logic
    output var logic        line_cycle,
    output var logic        display_reset,
    output var logic [3:0]  digital_in
);
    initial begin
        line_cycle = 1'b0;
        display_reset = 1'b0;
        digital_in = 4'h0;
    end

    // ========
    // Pulses: 0 line cycle, 1 display reset, 2 digital input 0
    // Held four clocks so the two-flop synchroniser cannot miss them
    task automatic pulse(input int which);
        @(posedge hclk);
        case (which)
            0: line_cycle <= 1'b1;
            1: display_reset <= 1'b1;
            default: digital_in[0] <= 1'b1;
        endcase
        repeat (4) @(posedge hclk);
        line_cycle <= 1'b0;
        display_reset <= 1'b0;
        digital_in <= 4'h0;
    endtask
endmodule
`default_nettype wire

// *** tb/alm_logic_module_test.sv ***
`timescale 1ns/10ps
`default_nettype none
`define CHK(g, e) begin checks_done++; if ((g) !== (e)) begin failures++; \
    $display("unexpected at %0t: %h vs %h", $time, (g), (e)); end end
module alm_logic_module_test
    import alm_pkg::*;
;
    // ========
    // Signals and model state
    localparam int GAP = 200;
    logic                      hclk = 1'b0;
    logic                      hresetn, hsel, hwrite, hready, hreadyout, hresp;
    logic [1:0]                htrans;
    logic [2:0]                hsize;
    logic [31:0]               haddr, hwdata, hrdata, rd;
    logic [ALM_NLIM-1:0][31:0] meas_value;
    logic                      line_cycle, display_reset;
    logic [3:0]                digital_in, limit_state, first_level_result;
    logic [3:0]                combined_logic_output, delayed_logic_state, function_output, follow_up;
    bit   [3:0]                lim, y, z, d, f, s, pend, lat, inv;
    int                        on[4], off[4], mv[4], sw[4], dr[4], cnt[4];
    int                        hrs, g1t, failures, checks_done, cyc;
    logic [7:0]  ca[17] = '{8'h04, 8'h08, 8'h20, 8'h24, 8'h28, 8'h40, 8'h44, 8'h48, 8'h4C,
                            8'h60, 8'h64, 8'h68, 8'h80, 8'h84, 8'h90, 8'h94, 8'hA0};
    logic [31:0] cd[17] = '{32'h38820, 32'h8000, 32'h4FC8, 32'h8000, 32'h8000, 32'h9, 32'h8001,
                            32'h8000, 32'h20003, 32'h25, 32'h18044, 32'h18008, 32'h64, 32'h32,
                            32'hA, 32'h14, 32'h1E};
    assign hready = hreadyout;
    always #10 hclk = ~hclk;

    alm_logic #(.GAP_CYC(GAP)) u_dut (.hclk(hclk), .hresetn(hresetn), .hsel(hsel),
        .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
        .hready(hready), .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp),
        .meas_value(meas_value), .line_cycle(line_cycle), .digital_in(digital_in),
        .display_reset(display_reset), .limit_state(limit_state),
        .first_level_result(first_level_result), .combined_logic_output(combined_logic_output),
        .delayed_logic_state(delayed_logic_state), .function_output(function_output),
        .follow_up(follow_up));
    alm_field u_far (.hclk(hclk), .line_cycle(line_cycle), .display_reset(display_reset),
        .digital_in(digital_in));

    // ========
    // Bus, model and comparison
    task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] wd);
        @(posedge hclk);
        hsel <= 1'b1;
        haddr <= {24'h0, a};
        htrans <= 2'h2;
        hwrite <= wr;
        hsize <= 3'h2;
        do @(posedge hclk); while (hready !== 1'b1);
        htrans <= 2'h0;
        hwdata <= wd;
        do @(posedge hclk); while (hready !== 1'b1);
        rd = hrdata;
        `CHK({hreadyout, hresp}, 2'b10)
    endtask
    function automatic bit gf(input int t, input bit [3:0] v, input bit [3:0] u);
        int n;
        int k;
        n = $countones(v & u);
        k = $countones(u);
        case (t)
            0: return n == k;
            1: return n > 0;
            2: return n == 1;
            3: return n != k;
            4: return n == 0;
            default: return n == 0 || n == k;
        endcase
    endfunction
    task automatic model_pass();
        bit [3:0] zp;
        int dl;
        zp = z;
        hrs += lim[0];
        for (int m = 0; m < 4; m++) begin
            if (on[m] >= off[m]) begin
                lim[m] = lim[m] ? !(mv[m] < off[m]) : (mv[m] > on[m]);
            end else begin
                lim[m] = lim[m] ? !(mv[m] > off[m]) : (mv[m] < on[m]);
            end
        end
        // Channel 1 also resets on the level of limit 1, read at the action stage
        pend[1] |= lim[1];
        y[0] = gf(g1t, {1'b0, lim[2:0]}, 4'h7);
        y[2:1] = lim[1:0];
        y[3] = gf(5, {2'b0, lim[2], y[0]}, 4'h3);
        z = {gf(4, {2'b0, zp[0], y[3]}, 4'h3), y[2:1], gf(g1t, {3'b0, y[0]}, 4'h1)};
        for (int c = 0; c < 4; c++) begin
            dl = z[c] ? sw[c] : dr[c];
            if (z[c] == d[c]) begin
                cnt[c] = 0;
            end else if (cnt[c] >= dl) begin
                d[c] = z[c];
                cnt[c] = 0;
            end else begin
                cnt[c]++;
            end
            f[c] = d[c] | (lat[c] & f[c] & !pend[c]);
        end
        pend = 4'h0;
        s = f ^ inv;
    endtask
    task automatic check_all();
        `CHK(limit_state, lim)
        `CHK(first_level_result, y)
        `CHK(combined_logic_output, z)
        `CHK(delayed_logic_state, d)
        `CHK(function_output, f)
        `CHK(follow_up, s)
    endtask
    task automatic run_pass();
        int r;
        if ($urandom_range(2) == 0) begin
            for (int m = 0; m < 3; m++) begin
                mv[m] = $urandom_range(m == 1 ? 40 : 130);
                meas_value[m] <= 32'(mv[m]);
            end
        end
        r = $urandom_range(5);
        if (r == 0) begin
            bus(1'b1, ALM_CMD, 32'h2);
        end else if (r < 3) begin
            u_far.pulse(r);
        end
        pend[1] = (r < 3);
        u_far.pulse(0);
        // Sync plus a nine-cycle pass ends well inside this wait
        repeat (16) @(posedge hclk);
        model_pass();
        check_all();
    endtask
    task automatic results();
        $display("checks %0d failures %0d", checks_done, failures);
        if (failures == 0 && checks_done > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask

    always @(posedge hclk) begin
        cyc++;
        if (cyc == 12000) begin
            failures++;
            results();
        end
    end

    // ========
    // Main sequence
    initial begin
        {hresetn, hsel, hwrite, htrans, haddr, hwdata, meas_value} = '0;
        hsize = 3'h2;
        on = '{32'h64, 32'hA, 32'h1E, 32'h0};
        off = '{32'h32, 32'h14, 32'h1E, 32'h0};
        sw[2] = 3;
        dr[2] = 2;
        lat = 4'h2;
        inv = 4'h2;
        void'($urandom(77642));
        repeat (6) @(posedge hclk);
        hresetn <= 1'b1;
        bus(1'b0, 8'h00, 32'h0);
        `CHK(rd, ALM_CH_CFG_RST)
        `CHK({limit_state, first_level_result, function_output, follow_up}, 16'h0)
        $display("test reset done");
        for (int i = 0; i < 17; i++) bus(1'b1, ca[i], cd[i]);
        bus(1'b1, 8'hA4, 32'h1E);
        // Every gate type at both levels of channel 0, random measured values
        for (int gt = 0; gt < 6; gt++) begin
            g1t = gt;
            bus(1'b1, 8'h00, 32'(gt * 9));
            repeat (12) run_pass();
            $display("test gate %0d done", gt);
        end
        // No line cycle: the gap timer alone must start a pass
        repeat (230) @(posedge hclk);
        model_pass();
        check_all();
        $display("test gap done");
        bus(1'b0, 8'h88, 32'h0);
        `CHK(rd, 32'(hrs))
        bus(1'b0, ALM_STATUS, 32'h0);
        `CHK(rd, {8'h00, s, f, d, z, y, lim})
        bus(1'b0, 8'hD0, 32'h0);
        `CHK(rd, 32'h0)
        $display("test registers done");
        results();
    end
endmodule
`default_nettype wire
